//--- rtl/mcg_pkg.sv
// Shared constants, field layouts and carrier types for the machine-check global block
`default_nettype none
package mcg_pkg;
    // Clock and watchdog time base
    localparam int CLK_PERIOD_NS = 5;
    localparam int US_NS = 1000;
    localparam int CYCLES_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int US_PER_MS = 1000;

    // Implementation size
    localparam int NUM_BANKS = 6;
    localparam int BANK_IDX_W = $clog2(NUM_BANKS);
    localparam logic [7:0] BANK_COUNT = 8'(NUM_BANKS);
    localparam logic CTL_PRESENT = 1'b1;

    // Register numbers on the MSR port
    localparam logic [31:0] ADDR_CAP = 32'h00000100;
    localparam logic [31:0] ADDR_STATUS = 32'h00000101;
    localparam logic [31:0] ADDR_CTL = 32'h00000102;
    localparam logic [31:0] ADDR_WDOG = 32'h00000103;
    localparam logic [31:0] ADDR_INTR_CFG = 32'hc0000410;

    // Field positions
    localparam int CAP_PRESENT_BIT = 8;
    localparam int ST_RESTART_BIT = 0;
    localparam int ST_FAULTING_BIT = 1;
    localparam int ST_PROGRESS_BIT = 2;
    localparam int CFG_THR_LSB = 12;
    localparam int CFG_DEF_LSB = 4;
    localparam int WD_EN_BIT = 0;
    localparam int WD_TB_LSB = 1;
    localparam int WD_CS_LSB = 3;
    localparam logic [11:0] VECTOR_BASE = 12'h500;

    // Values after reset
    localparam logic RST_FLAG = 1'b0;
    localparam logic [NUM_BANKS-1:0] RST_BANK_MASK = '0;
    localparam logic [3:0] RST_SLOT = 4'h0;
    localparam logic [1:0] RST_TB = 2'h0;
    localparam logic [3:0] RST_CS = 4'h0;

    // Watchdog time base codes and count table
    localparam logic [1:0] TB_MS = 2'h0;
    localparam logic [1:0] TB_US = 2'h1;
    localparam int WD_CNT_W = 14;
    localparam logic [3:0] CS_LAST = 4'h9;
    localparam logic [WD_CNT_W-1:0] WD_LIMIT [10] = '{
        14'hfff, 14'h7ff, 14'h3ff, 14'h1ff, 14'h0ff,
        14'h07f, 14'h03f, 14'h01f, 14'h1fff, 14'h3fff};

    typedef enum logic [1:0] {
        GS_RUN = 2'h1,
        GS_SHUTDOWN = 2'h2
    } gstate_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [63:0] wdata;
    } msr_req_t;

    typedef struct packed {
        logic ack;
        logic fault;
        logic [63:0] rdata;
    } msr_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] bank;
        logic restartValid;
        logic faultingValid;
        logic logAlways;
    } err_event_t;
endpackage : mcg_pkg
`default_nettype wire

//--- rtl/watchdog_prescaler.sv
// Microsecond and millisecond tick divider for the instruction watchdog
`default_nettype none
module watchdog_prescaler #(
    parameter int DIVIDE = mcg_pkg::CYCLES_PER_US
) (
    input wire logic sys_clk, // Core clock
    input wire logic resetn, // Synchronous reset, active low
    output logic usTick, // One-cycle pulse per microsecond
    output logic msTick // One-cycle pulse per millisecond
);
    typedef struct packed {
        logic [15:0] usCnt;
        logic [9:0] msCnt;
        logic usTick;
        logic msTick;
    } pre_state_t;

    pre_state_t s_reg;
    pre_state_t s_next;

    // Free-running; gating for halt is done in the timer so ticks stay aligned
    always_comb begin
        s_next = s_reg;
        s_next.usTick = 1'b0;
        s_next.msTick = 1'b0;
        if (s_reg.usCnt == 16'(DIVIDE - 1)) begin
            s_next.usCnt = 16'h0000;
            s_next.usTick = 1'b1;
            if (s_reg.msCnt == 10'(mcg_pkg::US_PER_MS - 1)) begin
                s_next.msCnt = 10'h000;
                s_next.msTick = 1'b1;
            end else begin
                s_next.msCnt = s_reg.msCnt + 10'h001;
            end
        end else begin
            s_next.usCnt = s_reg.usCnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign usTick = s_reg.usTick;
    assign msTick = s_reg.msTick;
endmodule : watchdog_prescaler
`default_nettype wire

//--- rtl/watchdog_timer.sv
// Instruction-completion watchdog counter with count-select lookup
`default_nettype none
module watchdog_timer (
    input wire logic sys_clk, // Core clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic enable, // Watchdog enable bit
    input wire logic [1:0] timeBase, // Time base code
    input wire logic [3:0] countSel, // Count select code
    input wire logic usTick, // Microsecond tick
    input wire logic msTick, // Millisecond tick
    input wire logic instrDone, // An instruction completed this cycle
    input wire logic halted, // Halt or stop-grant
    output logic expire // One-cycle timeout pulse
);
    typedef struct packed {
        logic [mcg_pkg::WD_CNT_W-1:0] count;
        logic expire;
    } wd_state_t;

    wd_state_t s_reg;
    wd_state_t s_next;
    logic tick;
    logic codesValid;
    logic [mcg_pkg::WD_CNT_W-1:0] limit;

    // Reserved codes keep the timer still rather than guess a period
    always_comb begin
        codesValid = (countSel <= mcg_pkg::CS_LAST) &&
            (timeBase == mcg_pkg::TB_MS || timeBase == mcg_pkg::TB_US);
        tick = (timeBase == mcg_pkg::TB_MS) ? msTick : usTick;
        limit = codesValid ? mcg_pkg::WD_LIMIT[countSel] : '1;
        s_next = s_reg;
        s_next.expire = 1'b0;
        if (!enable) begin
            s_next.count = s_reg.count;
        end else if (instrDone) begin
            s_next.count = '0;
        end else if (halted) begin
            s_next.count = s_reg.count;
        end else if (tick && codesValid) begin
            if (s_reg.count + 14'h0001 >= limit) begin
                s_next.count = '0;
                s_next.expire = 1'b1;
            end else begin
                s_next.count = s_reg.count + 14'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign expire = s_reg.expire;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_WD_RESTART: assert property (enable && instrDone |=> s_reg.count == '0)
        else $error("watchdog count not restarted on completion");
    AST_WD_HALT_HOLD: assert property (enable && halted && !instrDone |=> $stable(s_reg.count))
        else $error("watchdog advanced while halted");
    AST_WD_DISABLED: assert property (!enable |=> !expire && $stable(s_reg.count))
        else $error("disabled watchdog moved or expired");
endmodule : watchdog_timer
`default_nettype wire

//--- rtl/machine_check_global.sv
// Machine-check global registers, exception sequencing and instruction watchdog
// What this block does
// - Capability low byte reports bank count
// - Capability bit 8 shows control register present
// - Status bit 0: restart pointer is valid
// - Status bit 1: interrupted thread caused error
// - Set in-progress flag on every exception
// - Error during in-progress enters shutdown
// - Enable mask bits gate each bank
// - Some disabled-bank errors may still log
// - Threshold vector address from bits 15:12
// - Deferred vector address from bits 7:4
// - Watchdog timeout raises machine check
// - Completion restarts watchdog count
// - No counting while halted or stop-grant
// - Enable bit lets timer run
// - Time base: millisecond or microsecond
// - Timeout is count times time base
// - Count-select table of period values
`default_nettype none
module machine_check_global #(
    parameter int PRESCALE = mcg_pkg::CYCLES_PER_US
) (
    input wire logic sys_clk, // Core clock, 200 MHz
    input wire logic resetn, // Synchronous reset, active low
    input wire mcg_pkg::msr_req_t msrReq, // MSR read or write request
    output mcg_pkg::msr_rsp_t msrRsp, // MSR answer, one cycle later
    input wire mcg_pkg::err_event_t errEvent, // Error detected by a bank
    input wire logic instrDone, // Instruction completion strobe
    input wire logic halted, // Halt or stop-grant level
    output logic mcException, // Machine-check exception pulse
    output logic shutdown, // Shutdown state level
    output logic logStrobe, // Bank must log the error pulse
    output logic [mcg_pkg::NUM_BANKS-1:0] bankEnable, // Per-bank report enable
    output logic [11:0] thresholdVectorAddr, // Threshold vector entry address
    output logic [11:0] deferredVectorAddr // Deferred vector entry address
);
    typedef struct packed {
        logic restartValid;
        logic faultingValid;
        logic inProgress;
        logic [mcg_pkg::NUM_BANKS-1:0] bankMask;
        logic [3:0] thrSlot;
        logic [3:0] defSlot;
        logic wdEn;
        logic [1:0] wdTb;
        logic [3:0] wdCs;
        mcg_pkg::gstate_t gstate;
        mcg_pkg::msr_rsp_t rsp;
        logic mcPulse;
        logic logPulse;
    } mcg_state_t;

    mcg_state_t s_reg;
    mcg_state_t s_next;

    logic usTick;
    logic msTick;
    logic wdExpire;
    logic bankInRange;
    logic bankOn;
    logic reportable;
    logic raise;
    logic [63:0] wdata;

    // Tick source for the watchdog time base
    watchdog_prescaler #(
        .DIVIDE(PRESCALE)
    ) watchdog_prescaler_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .usTick(usTick),
        .msTick(msTick)
    );

    // Watchdog counter, steered by the watchdog configuration register
    watchdog_timer watchdog_timer_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .enable(s_reg.wdEn),
        .timeBase(s_reg.wdTb),
        .countSel(s_reg.wdCs),
        .usTick(usTick),
        .msTick(msTick),
        .instrDone(instrDone),
        .halted(halted),
        .expire(wdExpire)
    );

    // Error qualification; a bank number past the last bank is ignored
    always_comb begin
        bankInRange = errEvent.bank < mcg_pkg::BANK_COUNT;
        bankOn = bankInRange && s_reg.bankMask[errEvent.bank[mcg_pkg::BANK_IDX_W-1:0]];
        reportable = errEvent.valid && bankOn;
        raise = reportable || wdExpire;
        wdata = msrReq.wdata;
    end

    // Register access first, hardware events last so a set beats a clear
    always_comb begin
        s_next = s_reg;
        s_next.mcPulse = 1'b0;
        s_next.logPulse = 1'b0;
        s_next.rsp = '0;

        if (msrReq.valid) begin
            s_next.rsp.ack = 1'b1;
            if (msrReq.addr == mcg_pkg::ADDR_CAP) begin
                // Writes are dropped; the far side must not issue them
                if (!msrReq.write) begin
                    s_next.rsp.rdata[7:0] = mcg_pkg::BANK_COUNT;
                    s_next.rsp.rdata[mcg_pkg::CAP_PRESENT_BIT] = mcg_pkg::CTL_PRESENT;
                end
            end else if (msrReq.addr == mcg_pkg::ADDR_STATUS) begin
                if (msrReq.write) begin
                    s_next.restartValid = wdata[mcg_pkg::ST_RESTART_BIT];
                    s_next.faultingValid = wdata[mcg_pkg::ST_FAULTING_BIT];
                    s_next.inProgress = wdata[mcg_pkg::ST_PROGRESS_BIT];
                end else begin
                    s_next.rsp.rdata[mcg_pkg::ST_RESTART_BIT] = s_reg.restartValid;
                    s_next.rsp.rdata[mcg_pkg::ST_FAULTING_BIT] = s_reg.faultingValid;
                    s_next.rsp.rdata[mcg_pkg::ST_PROGRESS_BIT] = s_reg.inProgress;
                end
            end else if (msrReq.addr == mcg_pkg::ADDR_CTL) begin
                if (msrReq.write) begin
                    s_next.bankMask = wdata[mcg_pkg::NUM_BANKS-1:0];
                end else begin
                    s_next.rsp.rdata[mcg_pkg::NUM_BANKS-1:0] = s_reg.bankMask;
                end
            end else if (msrReq.addr == mcg_pkg::ADDR_INTR_CFG) begin
                if (msrReq.write) begin
                    s_next.thrSlot = wdata[mcg_pkg::CFG_THR_LSB +: 4];
                    s_next.defSlot = wdata[mcg_pkg::CFG_DEF_LSB +: 4];
                end else begin
                    s_next.rsp.rdata[mcg_pkg::CFG_THR_LSB +: 4] = s_reg.thrSlot;
                    s_next.rsp.rdata[mcg_pkg::CFG_DEF_LSB +: 4] = s_reg.defSlot;
                end
            end else if (msrReq.addr == mcg_pkg::ADDR_WDOG) begin
                // Reserved upper bits are should-be-zero and simply not stored
                if (msrReq.write) begin
                    s_next.wdEn = wdata[mcg_pkg::WD_EN_BIT];
                    s_next.wdTb = wdata[mcg_pkg::WD_TB_LSB +: 2];
                    s_next.wdCs = wdata[mcg_pkg::WD_CS_LSB +: 4];
                end else begin
                    s_next.rsp.rdata[mcg_pkg::WD_EN_BIT] = s_reg.wdEn;
                    s_next.rsp.rdata[mcg_pkg::WD_TB_LSB +: 2] = s_reg.wdTb;
                    s_next.rsp.rdata[mcg_pkg::WD_CS_LSB +: 4] = s_reg.wdCs;
                end
            end else begin
                s_next.rsp.fault = 1'b1;
            end
        end

        // Logging may proceed for a masked bank when the source insists
        if (errEvent.valid && bankInRange && (bankOn || errEvent.logAlways)) begin
            s_next.logPulse = 1'b1;
        end

        case (s_reg.gstate)
            mcg_pkg::GS_RUN: begin
                if (raise) begin
                    if (s_reg.inProgress) begin
                        s_next.gstate = mcg_pkg::GS_SHUTDOWN;
                    end else begin
                        s_next.mcPulse = 1'b1;
                        s_next.inProgress = 1'b1;
                        // A stuck instruction cannot be restarted but is the culprit
                        s_next.restartValid = reportable && errEvent.restartValid;
                        s_next.faultingValid = reportable ? errEvent.faultingValid : 1'b1;
                    end
                end
            end
            mcg_pkg::GS_SHUTDOWN: begin
                // Only reset leaves shutdown
                s_next.gstate = mcg_pkg::GS_SHUTDOWN;
            end
            default: begin
                s_next.gstate = mcg_pkg::GS_SHUTDOWN;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg.restartValid <= mcg_pkg::RST_FLAG;
            s_reg.faultingValid <= mcg_pkg::RST_FLAG;
            s_reg.inProgress <= mcg_pkg::RST_FLAG;
            s_reg.bankMask <= mcg_pkg::RST_BANK_MASK;
            s_reg.thrSlot <= mcg_pkg::RST_SLOT;
            s_reg.defSlot <= mcg_pkg::RST_SLOT;
            s_reg.wdEn <= mcg_pkg::RST_FLAG;
            s_reg.wdTb <= mcg_pkg::RST_TB;
            s_reg.wdCs <= mcg_pkg::RST_CS;
            s_reg.gstate <= mcg_pkg::GS_RUN;
            s_reg.rsp <= '0;
            s_reg.mcPulse <= 1'b0;
            s_reg.logPulse <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state
    assign msrRsp = s_reg.rsp;
    assign mcException = s_reg.mcPulse;
    assign shutdown = (s_reg.gstate == mcg_pkg::GS_SHUTDOWN);
    assign logStrobe = s_reg.logPulse;
    assign bankEnable = s_reg.bankMask;
    assign thresholdVectorAddr = {4'h0, s_reg.thrSlot, 4'h0} + mcg_pkg::VECTOR_BASE;
    assign deferredVectorAddr = {4'h0, s_reg.defSlot, 4'h0} + mcg_pkg::VECTOR_BASE;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Request and event shapes used by the checks below
    sequence capRead;
        msrReq.valid && !msrReq.write && msrReq.addr == mcg_pkg::ADDR_CAP;
    endsequence

    sequence freshRaise;
        raise && !s_reg.inProgress && s_reg.gstate == mcg_pkg::GS_RUN;
    endsequence

    sequence cfgWrite;
        msrReq.valid && msrReq.write && msrReq.addr == mcg_pkg::ADDR_INTR_CFG;
    endsequence

    sequence capWrite;
        msrReq.valid && msrReq.write && msrReq.addr == mcg_pkg::ADDR_CAP;
    endsequence

    sequence statusWrite;
        msrReq.valid && msrReq.write && msrReq.addr == mcg_pkg::ADDR_STATUS;
    endsequence

    sequence ctlWrite;
        msrReq.valid && msrReq.write && msrReq.addr == mcg_pkg::ADDR_CTL;
    endsequence

    // Capability reads
    AST_CAP_COUNT: assert property (capRead |=> msrRsp.ack && msrRsp.rdata[7:0] == 8'h06)
        else $error("bank count wrong on capability read");

    AST_CAP_PRESENT: assert property (capRead |=> msrRsp.rdata[8] && msrRsp.rdata[63:9] == '0)
        else $error("present bit or reserved bits wrong");

    // Flags captured on a fresh exception
    AST_RESTART_FLAG: assert property (freshRaise and reportable
        |=> s_reg.restartValid == $past(errEvent.restartValid))
        else $error("restart flag not captured from error");

    AST_FAULT_FLAG: assert property (freshRaise and !reportable
        |=> s_reg.faultingValid && !s_reg.restartValid)
        else $error("watchdog exception flags wrong");

    AST_PROGRESS_SET: assert property (freshRaise |=> mcException && s_reg.inProgress)
        else $error("exception without in-progress flag");

    // Nested error escalates
    AST_SHUTDOWN: assert property (raise && s_reg.inProgress && !shutdown
        |=> shutdown && !mcException ##1 shutdown)
        else $error("nested error did not shut down");

    // Masked banks raise no exception
    AST_MASKED: assert property (errEvent.valid && !bankOn && !wdExpire |=> !mcException)
        else $error("masked bank raised an exception");

    // Vector entry addresses follow the slots
    AST_THR_VEC: assert property (cfgWrite |=> thresholdVectorAddr ==
        {4'h0, $past(msrReq.wdata[15:12]), 4'h0} + 12'h500)
        else $error("threshold vector address wrong");

    AST_DEF_VEC: assert property (cfgWrite |=> deferredVectorAddr ==
        {4'h0, $past(msrReq.wdata[7:4]), 4'h0} + 12'h500)
        else $error("deferred vector address wrong");

    // Expiry raises like any other error
    AST_WD_RAISE: assert property (wdExpire && !s_reg.inProgress && !shutdown
        |=> mcException)
        else $error("watchdog expiry not raised");

    // Dropped write still answers, so software never hangs on it
    AST_CAP_WRITE: assert property (capWrite |=>
        msrRsp.ack && !msrRsp.fault && msrRsp.rdata == '0)
        else $error("capability write not answered cleanly");

    // Software clear lands when no event competes with it
    AST_STATUS_WRITE: assert property (statusWrite and !raise |=>
        s_reg.inProgress == $past(msrReq.wdata[mcg_pkg::ST_PROGRESS_BIT]))
        else $error("in-progress flag not written");

    // Mask lands in one cycle
    AST_MASK_WRITE: assert property (ctlWrite |=>
        bankEnable == $past(msrReq.wdata[mcg_pkg::NUM_BANKS-1:0]))
        else $error("bank enable mask not written");

    // Logging follows the mask, or the source that insists
    AST_LOG_ENABLED: assert property (reportable
        |=> logStrobe)
        else $error("enabled bank error not logged");

    AST_LOG_FORCED: assert property (errEvent.valid && bankInRange
        && errEvent.logAlways |=> logStrobe)
        else $error("forced log strobe missing");

    // Bank numbers past the last bank are ignored entirely
    AST_BANK_RANGE: assert property (errEvent.valid && !bankInRange && !wdExpire
        |=> !mcException && !logStrobe)
        else $error("out-of-range bank reported");

    // Only reset leaves shutdown
    AST_SHUT_STICKY: assert property (shutdown
        |=> shutdown && !mcException)
        else $error("shutdown left or exception raised");

    // Expiry only on a tick of the selected base, never on a reserved code
    AST_MS_BASE: assert property (s_reg.wdTb == mcg_pkg::TB_MS && !msTick
        |=> !wdExpire)
        else $error("ms watchdog expired off its tick");

    AST_US_BASE: assert property (s_reg.wdTb == mcg_pkg::TB_US && !usTick
        |=> !wdExpire)
        else $error("us watchdog expired off its tick");

    AST_RSVD_TB: assert property (s_reg.wdTb[1]
        |=> !wdExpire)
        else $error("reserved time base expired");

    AST_RSVD_CS: assert property (s_reg.wdCs > mcg_pkg::CS_LAST
        |=> !wdExpire)
        else $error("reserved count select expired");

    // Reserved status bits read as zero
    AST_STATUS_RSVD: assert property (msrReq.valid && !msrReq.write
        && msrReq.addr == mcg_pkg::ADDR_STATUS |=> msrRsp.rdata[63:3] == '0)
        else $error("reserved status bits not zero");
endmodule : machine_check_global
`default_nettype wire

//--- tb/machine_check_global_bench.sv
// Self-checking bench for the machine-check global block
`default_nettype none
module machine_check_global_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PRE = 2; // Short prescale keeps watchdog runs brief
    localparam int LIMIT = 8000; // Whole run needs about 2400 cycles
    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [63:0] wdata;
        logic [63:0] rdata;
        logic fault;
    } row_t;
    logic sys_clk;
    logic resetn;
    mcg_pkg::msr_req_t msrReq;
    mcg_pkg::msr_rsp_t msrRsp;
    mcg_pkg::err_event_t errEvent;
    logic instrDone;
    logic halted;
    logic mcException;
    logic shutdown;
    logic logStrobe;
    logic [mcg_pkg::NUM_BANKS-1:0] bankEnable;
    logic [11:0] thresholdVectorAddr;
    logic [11:0] deferredVectorAddr;
    logic [63:0] q;
    logic f;
    logic seen;
    int err_total;
    int tests_run;
    int cycles;
    int n;
    int lim;
    // Register accesses and the answers they should give
    row_t rows [11] = '{
        '{1'b0, mcg_pkg::ADDR_CAP, 64'h0, 64'h106, 1'b0},
        '{1'b1, mcg_pkg::ADDR_CAP, 64'hffff, 64'h0, 1'b0},
        '{1'b0, mcg_pkg::ADDR_CAP, 64'h0, 64'h106, 1'b0},
        '{1'b0, mcg_pkg::ADDR_STATUS, 64'h0, 64'h0, 1'b0},
        '{1'b1, mcg_pkg::ADDR_CTL, 64'hffffffffffffffff, 64'h0, 1'b0},
        '{1'b0, mcg_pkg::ADDR_CTL, 64'h0, 64'h3f, 1'b0},
        '{1'b1, mcg_pkg::ADDR_INTR_CFG, 64'hffffffffffff3a5f, 64'h0, 1'b0},
        '{1'b0, mcg_pkg::ADDR_INTR_CFG, 64'h0, 64'h3050, 1'b0},
        '{1'b1, mcg_pkg::ADDR_WDOG, 64'hfffffffffffffffe, 64'h0, 1'b0},
        '{1'b0, mcg_pkg::ADDR_WDOG, 64'h0, 64'h7e, 1'b0},
        '{1'b0, 32'h00000200, 64'h0, 64'h0, 1'b1}};
    // Watchdog settings that must not fire within 300 cycles, and the activity beside them
    logic [63:0] qcfg [6] = '{64'h3b, 64'h3b, 64'h3a, 64'h3d, 64'h39, 64'h53};
    int qmode [6] = '{1, 2, 0, 0, 0, 0};

    machine_check_global #(.PRESCALE(PRE)) machine_check_global_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .msrReq(msrReq),
        .msrRsp(msrRsp),
        .errEvent(errEvent),
        .instrDone(instrDone),
        .halted(halted),
        .mcException(mcException),
        .shutdown(shutdown),
        .logStrobe(logStrobe),
        .bankEnable(bankEnable),
        .thresholdVectorAddr(thresholdVectorAddr),
        .deferredVectorAddr(deferredVectorAddr)
    );

    // Core clock, 5 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [63:0] seenVal, input logic [63:0] expVal);
        tests_run++;
        if (seenVal !== expVal) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seenVal, expVal);
        end
    endtask : check

    // Request held over one taking edge; the answer stands in the next cycle
    task automatic msr(input logic w, input logic [31:0] a, input logic [63:0] d,
                       output logic [63:0] rd, output logic flt);
        @(negedge sys_clk);
        msrReq = '{1'b1, w, a, d};
        @(negedge sys_clk);
        msrReq.valid = 1'b0;
        rd = msrRsp.rdata;
        flt = msrRsp.fault;
        check(64'(msrRsp.ack), 64'h1);
    endtask : msr

    task automatic rd_chk(input logic [31:0] a, input logic [63:0] e);
        logic [63:0] v;
        logic flt;
        msr(1'b0, a, 64'h0, v, flt);
        check(v, e);
    endtask : rd_chk

    // One-cycle error pulse; outputs are looked at in the cycle after it
    task automatic err(input logic [7:0] b, input logic rv, input logic fv, input logic la);
        @(negedge sys_clk);
        errEvent = '{1'b1, b, rv, fv, la};
        @(negedge sys_clk);
        errEvent.valid = 1'b0;
    endtask : err

    task automatic do_reset();
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (16) @(negedge sys_clk);
        resetn = 1'b1;
        check(64'(shutdown), 64'h0);
        check(64'(bankEnable), 64'h0);
        check(64'(thresholdVectorAddr), 64'h500);
        check(64'(deferredVectorAddr), 64'h500);
        $display("Test reset done");
    endtask : do_reset

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            $display("Error at %0t: run timed out", $time);
            final_report();
        end
    end

    initial begin
        resetn = 1'b0;
        msrReq = '0;
        errEvent = '0;
        instrDone = 1'b0;
        halted = 1'b0;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        do_reset();
        for (int i = 0; i < 11; i++) begin
            msr(rows[i].write, rows[i].addr, rows[i].wdata, q, f);
            if (!rows[i].write) check(q, rows[i].rdata);
            check(64'(f), 64'(rows[i].fault));
        end
        check(64'(thresholdVectorAddr), 64'h530);
        check(64'(deferredVectorAddr), 64'h550);
        check(64'(bankEnable), 64'h3f);
        $display("Test register table done");
        // Enabled bank raises the exception and sets all three flags
        err(8'h02, 1'b1, 1'b1, 1'b0);
        check(64'(mcException), 64'h1);
        check(64'(logStrobe), 64'h1);
        rd_chk(mcg_pkg::ADDR_STATUS, 64'h7);
        msr(1'b1, mcg_pkg::ADDR_STATUS, 64'h0, q, f);
        // Masked bank: only a log-always source still logs; out-of-range bank 6 does not log even then
        msr(1'b1, mcg_pkg::ADDR_CTL, 64'h3b, q, f);
        err(8'h06, 1'b1, 1'b1, 1'b1);
        check(64'(mcException), 64'h0);
        check(64'(logStrobe), 64'h0);
        err(8'h02, 1'b0, 1'b0, 1'b1);
        check(64'(mcException), 64'h0);
        check(64'(logStrobe), 64'h1);
        err(8'h02, 1'b0, 1'b0, 1'b0);
        check(64'(logStrobe), 64'h0);
        // Second error while in progress escalates to shutdown
        err(8'h01, 1'b0, 1'b0, 1'b0);
        check(64'(mcException), 64'h1);
        rd_chk(mcg_pkg::ADDR_STATUS, 64'h4);
        err(8'h01, 1'b1, 1'b1, 1'b0);
        check(64'(shutdown), 64'h1);
        check(64'(mcException), 64'h0);
        err(8'h00, 1'b1, 1'b0, 1'b0);
        check(64'(mcException), 64'h0);
        check(64'(shutdown), 64'h1);
        $display("Test error sequencing done");
        do_reset();
        // Watchdog period on the microsecond base for three count codes
        for (int cs = 5; cs < 8; cs++) begin
            lim = (1 << (12 - cs)) - 1;
            msr(1'b1, mcg_pkg::ADDR_WDOG, 64'((cs << 3) | 3), q, f);
            instrDone = 1'b1;
            @(negedge sys_clk);
            instrDone = 1'b0;
            n = 0;
            while (mcException !== 1'b1 && n < lim * PRE + 40) begin
                @(negedge sys_clk);
                n++;
            end
            check(64'(n >= lim * PRE - 4 && n <= lim * PRE + 4), 64'h1);
            rd_chk(mcg_pkg::ADDR_STATUS, 64'h6);
            msr(1'b1, mcg_pkg::ADDR_WDOG, 64'h0, q, f);
            msr(1'b1, mcg_pkg::ADDR_STATUS, 64'h0, q, f);
        end
        $display("Test watchdog period done");
        // Settings and activity under which the watchdog stays silent
        for (int i = 0; i < 6; i++) begin
            msr(1'b1, mcg_pkg::ADDR_WDOG, qcfg[i], q, f);
            halted = (qmode[i] == 2);
            seen = 1'b0;
            for (int c = 0; c < 300; c++) begin
                @(negedge sys_clk);
                instrDone = (qmode[i] == 1) && (c % 20 == 0);
                if (mcException === 1'b1) seen = 1'b1;
            end
            instrDone = 1'b0;
            halted = 1'b0;
            check(64'(seen), 64'h0);
        end
        $display("Test watchdog silence done");
        final_report();
    end
endmodule : machine_check_global_bench
`default_nettype wire
